// ### src/alc_pkg.sv
// Purpose: shared constants and types for the audio control register bank
// Assumes: 9-bit register words, 7-bit register addresses
// Notes: timing figures are in microseconds at the shortest code
package alc_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 9;
    localparam logic [6:0] ADDR_MODE_HOLD = 7'h0d;
    localparam logic [6:0] ADDR_DECAY_ATTACK = 7'h0e;
    localparam logic [6:0] ADDR_SOFT_RESET = 7'h0f;
    localparam logic [6:0] ADDR_EXTRA_POWER = 7'h21;
    localparam logic [6:0] ADDR_SLEEP_MIC = 7'h22;
    localparam logic [6:0] ADDR_LINE_OUT = 7'h23;
    localparam logic [6:0] ADDR_ROUTING = 7'h24;
    localparam logic [6:0] ADDR_COMPAND = 7'h25;
    localparam logic [6:0] ADDR_CLOCK = 7'h26;
    localparam logic [6:0] ADDR_RATE = 7'h27;
    // write masks: bits outside read back zero
    localparam logic [8:0] MASK_MODE_HOLD = 9'h03f;
    localparam logic [8:0] MASK_DECAY_ATTACK = 9'h0ff;
    localparam logic [8:0] MASK_EXTRA_POWER = 9'h00c;
    localparam logic [8:0] MASK_SLEEP_MIC = 9'h043;
    localparam logic [8:0] MASK_LINE_OUT = 9'h00f;
    localparam logic [8:0] MASK_ROUTING = 9'h11b;
    localparam logic [8:0] MASK_COMPAND = 9'h007;
    localparam logic [8:0] MASK_CLOCK = 9'h1fe;
    localparam logic [8:0] MASK_RATE = 9'h00f;
    localparam logic [8:0] RESET_WORD = 9'h000;
    localparam logic [8:0] SOFT_RESET_CODE = 9'h000;
    // field positions
    localparam int POS_LIMITER = 5;
    localparam int POS_ZERO_CROSS = 4;
    localparam int POS_BIAS = 3;
    localparam int POS_BUFFER = 2;
    localparam int POS_SLEEP = 6;
    localparam int POS_BCLK_INV = 8;
    localparam int POS_RSLOT = 4;
    localparam int POS_LSLOT = 3;
    localparam int POS_SWAP = 1;
    localparam int POS_SINGLE_CHANNEL_OUT = 0;
    localparam int POS_CLK_SRC = 8;
    localparam int POS_LOOP_EN = 1;
    localparam int POS_SLOW_CLK = 0;
    // companding codes
    localparam logic [1:0] COMP_LINEAR = 2'h0;
    localparam logic [1:0] COMP_RESERVED = 2'h1;
    localparam logic [1:0] COMP_MULAW = 2'h2;
    localparam logic [1:0] COMP_ALAW = 2'h3;
    localparam logic [5:0] MU_OFFSET_LOW = 6'h20;
    localparam logic [5:0] MU_OFFSET_HIGH = 6'h21;
    localparam logic [23:0] ADC_MAX_CODE = 24'h7fffff;
    localparam logic [23:0] ADC_MIN_CODE = 24'h800000;
    // time per 0.75 dB step at code 0, in microseconds; core clock in MHz
    localparam int DECAY_NORMAL_US = 500;
    localparam int DECAY_LIMIT_US = 125;
    localparam int ATTACK_NORMAL_US = 125;
    localparam int ATTACK_LIMIT_US = 31;
    localparam int CLOCK_MHZ = 250;

    typedef struct packed {
        logic [8:0] mode_hold;
        logic [8:0] decay_attack;
        logic [8:0] extra_power;
        logic [8:0] sleep_mic;
        logic [8:0] line_out;
        logic [8:0] routing;
        logic [8:0] compand;
        logic [8:0] clock_cfg;
        logic [8:0] rate;
    } alc_regs_s;

    typedef struct packed {
        logic level_ctl_limiter_sel;
        logic level_ctl_zero_cross_en;
        logic [3:0] hold_time;
        logic [31:0] decay_step_cycles;
        logic [31:0] attack_step_cycles;
        logic analog_bias_en;
        logic tieoff_buffer_en;
        logic left_neg_input_to_ref;
        logic right_neg_input_to_ref;
        logic [1:0] left_lineout_mix;
        logic [1:0] right_lineout_mix;
        logic bitclk_invert;
        logic core_clock_run;
        logic loop_clock_source;
        logic [2:0] master_clk_divider;
        logic [2:0] bitclk_divider;
        logic [2:0] sample_rate_sel;
        logic slow_clock_en;
        logic [1:0] compand_mode;
        logic [5:0] mu_offset;
    } alc_cfg_s;

    typedef struct packed {
        logic [23:0] left;
        logic [23:0] right;
        logic left_valid;
        logic right_valid;
    } alc_slots_s;

    typedef struct packed {
        alc_regs_s regs;
        logic [8:0] rdata;
        logic prev_conv_en;
        alc_cfg_s cfg;
        alc_slots_s slots;
    } alc_state_s;
endpackage

// ### src/alc_ctrl_regs.sv
// Purpose: control register bank for level control, power, routing, clocks
// Assumes: serial control port already decoded into addr/data strobes
// Notes: all outputs registered; sample inputs share the core clock
//
// Overview of operation
// [RULE_01] mode bit selects normal or limiter timing
// [RULE_02] zero-cross bit gates gain changes
// [RULE_03] hold field, doubling steps up to one second
// [RULE_04] decay per step, range depends on mode
// [RULE_05] attack per step, range depends on mode
// [RULE_06] writing zero to reset register clears all; a legacy zero-cross in the same cycle still sets the slow clock bit
// [RULE_07] output codes clip at 0x7fffff maximum
// [RULE_08] write-only power bits: bias and buffer enables
// [RULE_09] sleep stops clock like loop enable
// [RULE_10] mic negative inputs tied to reference
// [RULE_11] line-out mix: none, left, right, both
// [RULE_12] bit clock inversion control
// [RULE_13] slot source selects cross channel data
// [RULE_14] swap bit exchanges left and right
// [RULE_15] single_channel_out outputs one channel, chosen by swap
// [RULE_16] companding: linear, mu-law, a-law; 01 reserved
// [RULE_17] mu-law offset 32 or 33
// [RULE_18] clock source and loop enable bits
// [RULE_19] master divider codes 1 to 12
// [RULE_20] bit clock divider codes 1 to 32
// [RULE_21] sample rate codes 48 down to 8 kHz
// [RULE_22] slow clock forced on by legacy zero-cross
// [RULE_23] legacy disable restores power register values
// [RULE_24] 9-bit words, unused bits read zero
`timescale 1ns/1ns
module alc_ctrl_regs (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register write/read port
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [6:0] addr,
    input wire logic [8:0] wdata,
    // legacy space side effects
    input wire logic legacy_left_conv_en,
    input wire logic legacy_right_conv_en,
    input wire logic legacy_zero_cross_set,
    // converter samples
    input wire logic [24:0] adc_left,
    input wire logic [24:0] adc_right,
    input wire logic adc_valid,
    // register read data
    output logic [8:0] rdata,
    // generated configuration
    output alc_pkg::alc_cfg_s cfg,
    // audio slots to the serial port
    output alc_pkg::alc_slots_s slots
);
    alc_pkg::alc_state_s st;
    alc_pkg::alc_state_s next_st;
    logic conv_en;
    logic [23:0] sat_left;
    logic [23:0] sat_right;
    logic [23:0] l_src;
    logic [23:0] r_src;
    logic [1:0] comp_field;

    // 25-bit signed input clamped into 24-bit range
    function automatic logic [23:0] clip24(input logic [24:0] v);
        logic [23:0] r;
        r = v[23:0];
        if (!v[24] && v[23]) begin
            r = alc_pkg::ADC_MAX_CODE; // [RULE_07]
        end else if (v[24] && !v[23]) begin
            r = alc_pkg::ADC_MIN_CODE;
        end
        return r;
    endfunction

    // step time at a code; shortest time doubles per code
    function automatic logic [31:0] step_cycles(input int base_us,
                                                input logic [3:0] code);
        logic [31:0] cyc;
        cyc = 32'(base_us * alc_pkg::CLOCK_MHZ);
        return cyc << code;
    endfunction

    assign conv_en = legacy_left_conv_en | legacy_right_conv_en;
    assign sat_left = clip24(adc_left);
    assign sat_right = clip24(adc_right);

    always_comb begin
        next_st = st;
        comp_field = st.regs.compand[2:1];
        // -----------------------------------------------------------------
        // register writes
        // -----------------------------------------------------------------
        if (wr_en) begin
            unique case (addr)
                alc_pkg::ADDR_MODE_HOLD: begin
                    next_st.regs.mode_hold = wdata & alc_pkg::MASK_MODE_HOLD;
                end
                alc_pkg::ADDR_DECAY_ATTACK: begin
                    next_st.regs.decay_attack =
                        wdata & alc_pkg::MASK_DECAY_ATTACK;
                end
                alc_pkg::ADDR_SOFT_RESET: begin
                    if (wdata == alc_pkg::SOFT_RESET_CODE) begin
                        next_st.regs = '0; // [RULE_06]
                    end
                end
                alc_pkg::ADDR_EXTRA_POWER: begin
                    next_st.regs.extra_power =
                        wdata & alc_pkg::MASK_EXTRA_POWER; // [RULE_08]
                end
                alc_pkg::ADDR_SLEEP_MIC: begin
                    next_st.regs.sleep_mic = wdata & alc_pkg::MASK_SLEEP_MIC;
                end
                alc_pkg::ADDR_LINE_OUT: begin
                    next_st.regs.line_out = wdata & alc_pkg::MASK_LINE_OUT;
                end
                alc_pkg::ADDR_ROUTING: begin
                    next_st.regs.routing = wdata & alc_pkg::MASK_ROUTING;
                end
                alc_pkg::ADDR_COMPAND: begin
                    next_st.regs.compand = wdata & alc_pkg::MASK_COMPAND;
                end
                alc_pkg::ADDR_CLOCK: begin
                    next_st.regs.clock_cfg = wdata & alc_pkg::MASK_CLOCK;
                end
                alc_pkg::ADDR_RATE: begin
                    next_st.regs.rate = wdata & alc_pkg::MASK_RATE;
                end
                default: begin
                end
            endcase
        end
        // legacy zero-cross write forces the slow clock on
        if (legacy_zero_cross_set) begin
            next_st.regs.rate[alc_pkg::POS_SLOW_CLK] = 1'b1; // [RULE_22]
        end
        next_st.prev_conv_en = conv_en;
        // -----------------------------------------------------------------
        // read back; write-only words and unmapped addresses read zero
        // -----------------------------------------------------------------
        next_st.rdata = '0;
        if (rd_en) begin
            unique case (addr)
                alc_pkg::ADDR_MODE_HOLD: next_st.rdata = st.regs.mode_hold;
                alc_pkg::ADDR_DECAY_ATTACK: begin
                    next_st.rdata = st.regs.decay_attack;
                end
                alc_pkg::ADDR_SLEEP_MIC: next_st.rdata = st.regs.sleep_mic;
                alc_pkg::ADDR_LINE_OUT: next_st.rdata = st.regs.line_out;
                alc_pkg::ADDR_ROUTING: next_st.rdata = st.regs.routing;
                alc_pkg::ADDR_COMPAND: next_st.rdata = st.regs.compand;
                alc_pkg::ADDR_CLOCK: next_st.rdata = st.regs.clock_cfg;
                alc_pkg::ADDR_RATE: next_st.rdata = st.regs.rate;
                default: next_st.rdata = '0; // [RULE_24]
            endcase
        end
        // -----------------------------------------------------------------
        // configuration outputs
        // -----------------------------------------------------------------
        next_st.cfg.level_ctl_limiter_sel =
            st.regs.mode_hold[alc_pkg::POS_LIMITER]; // [RULE_01]
        next_st.cfg.level_ctl_zero_cross_en =
            st.regs.mode_hold[alc_pkg::POS_ZERO_CROSS]; // [RULE_02]
        next_st.cfg.hold_time = st.regs.mode_hold[3:0]; // [RULE_03]
        // limiter mode shortens the decay and attack ranges
        if (st.regs.mode_hold[alc_pkg::POS_LIMITER]) begin
            next_st.cfg.decay_step_cycles = step_cycles(
                alc_pkg::DECAY_LIMIT_US, st.regs.decay_attack[7:4]);
            next_st.cfg.attack_step_cycles = step_cycles(
                alc_pkg::ATTACK_LIMIT_US, st.regs.decay_attack[3:0]);
        end else begin
            next_st.cfg.decay_step_cycles = step_cycles(
                alc_pkg::DECAY_NORMAL_US,
                st.regs.decay_attack[7:4]); // [RULE_04]
            next_st.cfg.attack_step_cycles = step_cycles(
                alc_pkg::ATTACK_NORMAL_US,
                st.regs.decay_attack[3:0]); // [RULE_05]
        end
        // legacy enable overrides bias/buffer; its release restores
        if (conv_en) begin
            next_st.cfg.analog_bias_en = 1'b1;
            next_st.cfg.tieoff_buffer_en = 1'b1;
        end else begin
            next_st.cfg.analog_bias_en =
                st.regs.extra_power[alc_pkg::POS_BIAS]; // [RULE_23] [RULE_08]
            next_st.cfg.tieoff_buffer_en =
                st.regs.extra_power[alc_pkg::POS_BUFFER];
        end
        next_st.cfg.left_neg_input_to_ref =
            st.regs.sleep_mic[1] | legacy_left_conv_en; // [RULE_10]
        next_st.cfg.right_neg_input_to_ref =
            st.regs.sleep_mic[0] | legacy_right_conv_en;
        next_st.cfg.left_lineout_mix = st.regs.line_out[3:2]; // [RULE_11]
        next_st.cfg.right_lineout_mix = st.regs.line_out[1:0];
        next_st.cfg.bitclk_invert =
            st.regs.routing[alc_pkg::POS_BCLK_INV]; // [RULE_12]
        // clock runs only with the loop on and not asleep
        next_st.cfg.core_clock_run =
            st.regs.clock_cfg[alc_pkg::POS_LOOP_EN] &
            ~st.regs.sleep_mic[alc_pkg::POS_SLEEP]; // [RULE_09]
        next_st.cfg.loop_clock_source =
            st.regs.clock_cfg[alc_pkg::POS_CLK_SRC]; // [RULE_18]
        next_st.cfg.master_clk_divider = st.regs.clock_cfg[7:5]; // [RULE_19]
        next_st.cfg.bitclk_divider = st.regs.clock_cfg[4:2]; // [RULE_20]
        next_st.cfg.sample_rate_sel = st.regs.rate[3:1]; // [RULE_21]
        next_st.cfg.slow_clock_en = st.regs.rate[alc_pkg::POS_SLOW_CLK];
        // reserved code falls back to linear rather than undefined coding
        next_st.cfg.compand_mode = (comp_field == alc_pkg::COMP_RESERVED) ?
            alc_pkg::COMP_LINEAR : comp_field; // [RULE_16]
        next_st.cfg.mu_offset = st.regs.compand[0] ?
            alc_pkg::MU_OFFSET_HIGH : alc_pkg::MU_OFFSET_LOW; // [RULE_17]
        // -----------------------------------------------------------------
        // audio slot routing
        // -----------------------------------------------------------------
        l_src = st.regs.routing[alc_pkg::POS_LSLOT] ?
            sat_right : sat_left; // [RULE_13]
        r_src = st.regs.routing[alc_pkg::POS_RSLOT] ? sat_left : sat_right;
        if (adc_valid) begin
            if (st.regs.routing[alc_pkg::POS_SWAP]) begin
                next_st.slots.left = r_src; // [RULE_14]
                next_st.slots.right = l_src;
            end else begin
                next_st.slots.left = l_src;
                next_st.slots.right = r_src;
            end
            next_st.slots.left_valid = 1'b1;
            next_st.slots.right_valid = 1'b1;
            if (st.regs.routing[alc_pkg::POS_SINGLE_CHANNEL_OUT]) begin
                next_st.slots.left_valid =
                    ~st.regs.routing[alc_pkg::POS_SWAP]; // [RULE_15]
                next_st.slots.right_valid =
                    st.regs.routing[alc_pkg::POS_SWAP];
            end
        end else begin
            next_st.slots.left_valid = 1'b0;
            next_st.slots.right_valid = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign cfg = st.cfg;
    assign slots = st.slots;

    // ---------------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------------
    AST_LIMITER_SEL: assert property (@(posedge clock) // [RULE_01]
        disable iff (!rst_n) wr_en && addr == alc_pkg::ADDR_MODE_HOLD ##2 1
        |-> cfg.level_ctl_limiter_sel == $past(wdata[5], 2)
        || $past(wr_en, 1)) else $error("limiter select mismatch");
    AST_ZERO_CROSS: assert property (@(posedge clock) // [RULE_02]
        disable iff (!rst_n)
        cfg.level_ctl_zero_cross_en == $past(st.regs.mode_hold[4]))
        else $error("zero cross enable mismatch");
    AST_SOFT_RESET: assert property (@(posedge clock) // [RULE_06]
        disable iff (!rst_n)
        wr_en && addr == alc_pkg::ADDR_SOFT_RESET && wdata == 9'h000
        && !legacy_zero_cross_set |=> st.regs == '0)
        else $error("software reset did not clear");
    AST_MAX_CODE: assert property (@(posedge clock) // [RULE_07]
        disable iff (!rst_n)
        adc_valid && !adc_left[24] && adc_left[23] && !st.regs.routing[3]
        && !st.regs.routing[1] |=> slots.left == 24'h7fffff)
        else $error("positive clip wrong");
    AST_WO_READ: assert property (@(posedge clock) // [RULE_08]
        disable iff (!rst_n)
        rd_en && addr == alc_pkg::ADDR_EXTRA_POWER |=> rdata == 9'h000)
        else $error("write-only register read nonzero");
    AST_SLEEP: assert property (@(posedge clock) // [RULE_09]
        disable iff (!rst_n)
        $past(st.regs.sleep_mic[6]) |-> !cfg.core_clock_run)
        else $error("sleep did not stop clock");
    AST_SINGLE_CHANNEL_OUT: assert property (@(posedge clock) // [RULE_15]
        disable iff (!rst_n) adc_valid && st.regs.routing[0] |=>
        (slots.left_valid != slots.right_valid) &&
        slots.right_valid == $past(st.regs.routing[1]))
        else $error("single_channel_out slot selection wrong");
    AST_COMPAND: assert property (@(posedge clock) // [RULE_16]
        disable iff (!rst_n) cfg.compand_mode != 2'h1 &&
        cfg.compand_mode[1] == $past(st.regs.compand[2]))
        else $error("reserved coding");
    AST_SLOW_CLK: assert property (@(posedge clock) // [RULE_22]
        disable iff (!rst_n) legacy_zero_cross_set |=> ##1 cfg.slow_clock_en)
        else $error("slow clock not forced");
    AST_RESTORE: assert property (@(posedge clock) // [RULE_23]
        disable iff (!rst_n) $fell(conv_en) |=>
        cfg.analog_bias_en == $past(st.regs.extra_power[3]))
        else $error("bias not restored");
    AST_UNUSED_BITS: assert property (@(posedge clock) // [RULE_24]
        disable iff (!rst_n)
        rd_en && addr == alc_pkg::ADDR_ROUTING |=> (rdata & 9'h0e4) == 9'h000)
        else $error("unused bits read nonzero");
endmodule

// ### tb/alc_host_model.sv
// Purpose: host side model that reaches the register bank
// Assumes: one strobe cycle per access, read data one cycle later
// Notes: address and data lines show garbage while idle
`timescale 1ns/1ns
module alc_host_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    output logic wr_en,
    output logic rd_en,
    output logic [6:0] addr,
    output logic [8:0] wdata,
    input wire logic [8:0] rdata
);
    logic zc_on = 1'b0;

    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 7'h7f;
        wdata = 9'h1ff;
    end

    // ----------------------------------------
    // accesses
    // ----------------------------------------
    // idle lines carry the inverse so stale values never look valid
    task automatic write(input logic [6:0] a, input logic [8:0] d,
                         output logic [8:0] sent);
        sent = d;
        if (a == alc_pkg::ADDR_MODE_HOLD)
            zc_on = d[alc_pkg::POS_ZERO_CROSS];
        if (a == alc_pkg::ADDR_RATE && zc_on)
            sent[alc_pkg::POS_SLOW_CLK] = 1'b1;
        wait (rst_n);
        @(posedge clock);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= sent;
        @(posedge clock);
        wr_en <= 1'b0;
        addr <= ~a;
        wdata <= ~sent;
    endtask

    task automatic read(input logic [6:0] a, output logic [8:0] q);
        wait (rst_n);
        @(posedge clock);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        addr <= ~a;
        #1;
        q = rdata;
    endtask

    task automatic soft_reset();
        logic [8:0] s;
        write(alc_pkg::ADDR_SOFT_RESET, alc_pkg::SOFT_RESET_CODE, s);
        zc_on = 1'b0;
    endtask
endmodule

// ### tb/audio_adc_control_registers_tb.sv
// Purpose: self-checking bench for the control register bank
// Assumes: host model drives the register port
// Notes: reserved codes are never programmed by the host
`timescale 1ns/1ns
`define CHK(a, e, m) begin cmp_count++; if ((a) !== (e)) begin \
    error_cnt++; $display("FAIL t=%0t %s", $time, m); end end
module audio_adc_control_registers_tb;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic wr_en;
    logic rd_en;
    logic [6:0] addr;
    logic [8:0] wdata;
    logic [8:0] rdata;
    logic leg_l = 1'b0;
    logic leg_r = 1'b0;
    logic leg_zc = 1'b0;
    logic [24:0] adc_l = '0;
    logic [24:0] adc_r = '0;
    logic adc_v = 1'b0;
    alc_pkg::alc_cfg_s cfg;
    alc_pkg::alc_slots_s slots;
    logic [8:0] img [0:127];
    logic [31:0] seed = 32'h4ae96887;
    int error_cnt = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [6:0] alist [12] = '{7'h0d, 7'h0e, 7'h0f, 7'h21, 7'h22, 7'h23,
        7'h24, 7'h25, 7'h26, 7'h27, 7'h10, 7'h28};
    logic [6:0] ca [10] = '{7'h0d, 7'h0e, 7'h0d, 7'h22, 7'h26, 7'h22,
        7'h25, 7'h25, 7'h25, 7'h25};
    logic [8:0] cd [10] = '{9'h020, 9'h0ff, 9'h000, 9'h040, 9'h002,
        9'h000, 9'h004, 9'h005, 9'h006, 9'h000};
    logic [8:0] rl [8] = '{9'h000, 9'h008, 9'h010, 9'h018, 9'h002,
        9'h001, 9'h003, 9'h100};

    always #2 clock = ~clock;

    alc_ctrl_regs i_dut (.clock(clock), .rst_n(rst_n), .wr_en(wr_en),
        .rd_en(rd_en), .addr(addr), .wdata(wdata),
        .legacy_left_conv_en(leg_l), .legacy_right_conv_en(leg_r),
        .legacy_zero_cross_set(leg_zc), .adc_left(adc_l),
        .adc_right(adc_r), .adc_valid(adc_v), .rdata(rdata),
        .cfg(cfg), .slots(slots));

    alc_host_model i_host (.clock(clock), .rst_n(rst_n), .wr_en(wr_en),
        .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata));

    // ----------------------------------------
    // expectations
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    function automatic logic [8:0] wmask(logic [6:0] a);
        case (a)
            7'h0d: return alc_pkg::MASK_MODE_HOLD;
            7'h0e: return alc_pkg::MASK_DECAY_ATTACK;
            7'h21: return alc_pkg::MASK_EXTRA_POWER;
            7'h22: return alc_pkg::MASK_SLEEP_MIC;
            7'h23: return alc_pkg::MASK_LINE_OUT;
            7'h24: return alc_pkg::MASK_ROUTING;
            7'h25: return alc_pkg::MASK_COMPAND;
            7'h26: return alc_pkg::MASK_CLOCK;
            7'h27: return alc_pkg::MASK_RATE;
            default: return 9'h000;
        endcase
    endfunction

    // keep the host away from reserved codes and the reset value
    function automatic logic [8:0] legal(logic [6:0] a, logic [8:0] d);
        logic [8:0] r;
        r = d;
        if (a == 7'h0f)
            r[0] = 1'b1;
        if (a == 7'h25 && r[2:1] == 2'h1)
            r[2] = 1'b1;
        if (a == 7'h26 && r[4:3] == 2'h3)
            r[3] = 1'b0;
        if (a == 7'h27 && r[3:2] == 2'h3)
            r[2] = 1'b0;
        return r;
    endfunction

    function automatic alc_pkg::alc_cfg_s exp_cfg();
        alc_pkg::alc_cfg_s e;
        logic [8:0] m;
        int dn;
        int an;
        m = img[7'h0d];
        dn = m[5] ? alc_pkg::DECAY_LIMIT_US : alc_pkg::DECAY_NORMAL_US;
        an = m[5] ? alc_pkg::ATTACK_LIMIT_US : alc_pkg::ATTACK_NORMAL_US;
        dn = dn * alc_pkg::CLOCK_MHZ;
        an = an * alc_pkg::CLOCK_MHZ;
        e = '0;
        e.level_ctl_limiter_sel = m[5];
        e.level_ctl_zero_cross_en = m[4];
        e.hold_time = m[3:0];
        e.decay_step_cycles = 32'(dn) << img[7'h0e][7:4];
        e.attack_step_cycles = 32'(an) << img[7'h0e][3:0];
        e.analog_bias_en = img[7'h21][3];
        e.tieoff_buffer_en = img[7'h21][2];
        e.left_neg_input_to_ref = img[7'h22][1];
        e.right_neg_input_to_ref = img[7'h22][0];
        e.left_lineout_mix = img[7'h23][3:2];
        e.right_lineout_mix = img[7'h23][1:0];
        e.bitclk_invert = img[7'h24][8];
        e.core_clock_run = img[7'h26][1] & ~img[7'h22][6];
        e.loop_clock_source = img[7'h26][8];
        e.master_clk_divider = img[7'h26][7:5];
        e.bitclk_divider = img[7'h26][4:2];
        e.sample_rate_sel = img[7'h27][3:1];
        e.slow_clock_en = img[7'h27][0];
        e.compand_mode = img[7'h25][2:1];
        e.mu_offset = img[7'h25][0] ? alc_pkg::MU_OFFSET_HIGH :
            alc_pkg::MU_OFFSET_LOW;
        return e;
    endfunction

    function automatic logic [23:0] clip(logic [24:0] x);
        if (!x[24] && x[23])
            return 24'h7fffff;
        if (x[24] && !x[23])
            return 24'h800000;
        return x[23:0];
    endfunction

    // ----------------------------------------
    // stimulus tasks
    // ----------------------------------------
    task automatic op(logic [6:0] a, logic [8:0] d);
        logic [8:0] s;
        logic [8:0] q;
        i_host.write(a, legal(a, d), s);
        img[a] = s & wmask(a);
        i_host.read(a, q);
        `CHK(q, (a == 7'h21) ? 9'h000 : img[a], "readback")
        `CHK(cfg, exp_cfg(), "cfg")
    endtask

    task automatic sample(logic [24:0] l, logic [24:0] r);
        alc_pkg::alc_slots_s e;
        logic [8:0] ro;
        logic [23:0] ms;
        ro = img[7'h24];
        e.left = ro[3] ? clip(r) : clip(l);
        e.right = ro[4] ? clip(l) : clip(r);
        if (ro[1])
            e = '{e.right, e.left, 1'b0, 1'b0};
        e.left_valid = ~ro[0] | ~ro[1];
        e.right_valid = ~ro[0] | ro[1];
        @(posedge clock);
        adc_l <= l;
        adc_r <= r;
        adc_v <= 1'b1;
        @(posedge clock);
        adc_v <= 1'b0;
        #1;
        `CHK(slots.left_valid, e.left_valid, "left valid")
        `CHK(slots.right_valid, e.right_valid, "right valid")
        ms = ro[1] ? slots.right : slots.left;
        `CHK(ms, ro[1] ? e.right : e.left, "single_channel_out data")
        if (!ro[0])
            `CHK(slots, e, "slots")
    endtask

    task automatic legacy(logic l, logic r);
        @(posedge clock);
        leg_l <= l;
        leg_r <= r;
        repeat (3) @(posedge clock);
        #1;
    endtask

    task automatic tdone(string n);
        $display("test %s done", n);
    endtask

    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // a healthy run needs about 830 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 10000) begin
            error_cnt++;
            finish_test();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [8:0] q;
        logic [31:0] r;
        foreach (img[i])
            img[i] = 9'h000;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        foreach (alist[i]) begin
            i_host.read(alist[i], q);
            `CHK(q, 9'h000, "reset value")
        end
        `CHK(cfg, exp_cfg(), "reset cfg")
        tdone("reset");
        foreach (ca[i])
            op(ca[i], cd[i]);
        repeat (150) begin
            r = rnd();
            op(alist[r[3:0] % 12], r[16:8]);
        end
        tdone("registers");
        op(7'h21, 9'h00c);
        i_host.soft_reset();
        foreach (img[i])
            img[i] = 9'h000;
        foreach (alist[i]) begin
            i_host.read(alist[i], q);
            `CHK(q, 9'h000, "soft reset")
        end
        `CHK(cfg, exp_cfg(), "soft reset cfg")
        tdone("soft reset");
        op(7'h21, 9'h008);
        legacy(1'b1, 1'b0);
        `CHK(cfg.analog_bias_en & cfg.tieoff_buffer_en, 1'b1, "leg on")
        `CHK(cfg.left_neg_input_to_ref, 1'b1, "leg mic")
        legacy(1'b0, 1'b0);
        `CHK(cfg, exp_cfg(), "leg off")
        legacy(1'b0, 1'b1);
        `CHK(cfg.right_neg_input_to_ref, 1'b1, "leg mic r")
        legacy(1'b0, 1'b0);
        `CHK(cfg, exp_cfg(), "leg off r")
        @(posedge clock);
        leg_zc <= 1'b1;
        @(posedge clock);
        leg_zc <= 1'b0;
        img[7'h27][0] = 1'b1;
        i_host.read(7'h27, q);
        `CHK(q, img[7'h27], "zc set")
        `CHK(cfg, exp_cfg(), "zc cfg")
        tdone("legacy");
        foreach (rl[i]) begin
            op(7'h24, rl[i]);
            sample(25'h0800000, 25'h17fffff);
            sample(25'h07fffff, 25'h1800000);
            repeat (3) begin
                r = rnd();
                sample(r[24:0], {r[7:0], r[31:15]});
            end
        end
        tdone("slots");
        finish_test();
    end
endmodule
